/* logic/sct_defs.svh */
// Offsets, field positions, reset values and counts of the core bus timing block.
// Assumes inclusion by bare name from the package only; the modules see its macros through it.
`ifndef SCT_DEFS_SVH
`define SCT_DEFS_SVH
// Register indices; byte address is four times the index
`define SCT_IDX_PWR 8'h87
`define SCT_IDX_TIMER01_CONTROL 8'h88
`define SCT_IDX_TL0 8'h8A
`define SCT_IDX_TH0 8'h8C
`define SCT_IDX_XSTAT 8'h9E
`define SCT_IDX_WAIT 8'h9F
`define SCT_IDX_TIMER2_CONTROL 8'hC8
`define SCT_IDX_TL2 8'hCC
`define SCT_IDX_TH2 8'hCD
`define SCT_IDX_PLL 8'hD7
// Reset values
`define SCT_RST_PWR 8'h00
`define SCT_RST_TIMER01_CONTROL 8'h00
`define SCT_RST_CNT 8'h00
`define SCT_RST_TIMER2_CONTROL 8'h00
`define SCT_RST_WAIT 8'h00
`define SCT_RST_PLL 8'h03
// Field positions
`define SCT_PWR_ALE_OFF 4
`define SCT_TIMER01_CONTROL_TF0 5
`define SCT_TIMER01_CONTROL_TR0 4
`define SCT_TIMER2_CONTROL_TF2 7
`define SCT_TIMER2_CONTROL_TR2 2
`define SCT_XSTAT_BUSY 0
`define SCT_XSTAT_REFUSED 1
// Timing
`define SCT_PLL_MHZ_X100 1258
`define SCT_MIN_CORE_CLKS 8'h02
`endif

/* logic/sct_pkg.sv */
// Types shared by the core bus timing block.
// Assumes sct_defs.svh is on the include path.
package sct_pkg;
  `include "sct_defs.svh"
  typedef enum logic [1:0] {
    SCT_X_IDLE = 2'b00,
    SCT_X_ADDR = 2'b01,
    SCT_X_STRB = 2'b10
  } sct_xphase_t;
  typedef logic [7:0] sct_byte_t;
endpackage

/* logic/sct_clkdiv.sv */
// Core clock divider: makes machine cycle ticks and the half-cycle phase.
// Assumes clk_i is the PLL clock; divide setting comes from a register.
`timescale 1ns/100ps
module sct_clkdiv
  import sct_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic [2:0] div_i,
  // Timing
  output logic tick_o,
  output logic first_half_o
);
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] len;
  } sct_div_st_t;
  sct_div_st_t s_q, s_d;

  // A half cycle needs at least one clk_i, so the shortest core cycle is two
  always_comb begin
    s_d = s_q;
    if (s_q.cnt == s_q.len - 8'h01) begin
      s_d.cnt = 8'h00;
      s_d.len = 8'(`SCT_MIN_CORE_CLKS << div_i);
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.cnt <= 8'h00;
      s_q.len <= `SCT_MIN_CORE_CLKS;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = (s_q.cnt == s_q.len - 8'h01);
  assign first_half_o = (s_q.cnt < (s_q.len >> 1));
endmodule

/* logic/sct_xmem.sv */
// External data memory sequencer on the multiplexed port.
// Assumes start arrives with a machine cycle tick; port pins come from outside.
`timescale 1ns/100ps
module sct_xmem
  import sct_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Core side
  input wire logic tick_i,
  input wire logic start_i,
  input wire logic we_i,
  input wire logic [23:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] wait_i,
  input wire logic first_half_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  // Pins
  input wire logic [7:0] port0_i,
  output logic [7:0] port0_o,
  output logic port0_oe_o,
  output logic [7:0] port2_o,
  output logic rd_n_o,
  output logic wr_n_o
);
  typedef struct packed {
    sct_xphase_t ph;
    logic we;
    logic [23:0] addr;
    logic [7:0] wdata;
    logic [7:0] left;
    logic [7:0] rdata;
    logic done;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] filt;
  } sct_x_st_t;
  sct_x_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.s1 = port0_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3) begin
      s_d.filt = s_q.s3;
    end
    case (s_q.ph)
      SCT_X_IDLE: begin
        if (start_i) begin
          s_d.ph = SCT_X_ADDR;
          s_d.we = we_i;
          s_d.addr = addr_i;
          s_d.wdata = wdata_i;
          s_d.left = wait_i;
        end
      end
      SCT_X_ADDR: begin
        if (tick_i) begin
          s_d.ph = SCT_X_STRB;
        end
      end
      SCT_X_STRB: begin
        if (tick_i) begin
          if (s_q.left == 8'h00) begin
            s_d.ph = SCT_X_IDLE;
            s_d.done = 1'b1;
            if (!s_q.we) begin
              s_d.rdata = s_q.filt;
            end
            // Back-to-back transfers: the next one is taken on this same last tick
            if (start_i) begin
              s_d.ph = SCT_X_ADDR;
              s_d.we = we_i;
              s_d.addr = addr_i;
              s_d.wdata = wdata_i;
              s_d.left = wait_i;
            end
          end else begin
            s_d.left = s_q.left - 8'h01;
          end
        end
      end
      default: s_d.ph = SCT_X_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_o = (s_q.ph != SCT_X_IDLE);
  assign done_o = s_q.done;
  assign rdata_o = s_q.rdata;
  // Page byte shares the latch strobe, then the high address byte follows
  assign port2_o = (s_q.ph == SCT_X_ADDR && first_half_i) ? s_q.addr[23:16] : s_q.addr[15:8];
  // Ones are driven actively; the port floats only when idle or during a read strobe
  assign port0_o = (s_q.ph == SCT_X_ADDR) ? s_q.addr[7:0] : s_q.wdata;
  assign port0_oe_o = (s_q.ph == SCT_X_ADDR) || (s_q.ph == SCT_X_STRB && s_q.we);
  assign rd_n_o = !(s_q.ph == SCT_X_STRB && !s_q.we);
  assign wr_n_o = !(s_q.ph == SCT_X_STRB && s_q.we);
endmodule

/* logic/sct_top.sv */
// Core bus timing: latch strobe, timer ticks, external data cycles, registers.
// Assumes a Wishbone classic master and an instruction sequencer on clk_i.
//
// Contract
// - Timers advance once per core clock cycle.
// - Single-cycle instruction: strobe high first half.
// - Multi-cycle instruction: strobe high only first half.
// - No external program fetch, ever.
// - Data transfers lengthened by programmed wait count.
// - Core clock is divided PLL clock.
// - Divider zero runs core undivided; the code still takes two clk_i per core cycle.
// - Power control bit 4 suppresses strobe.
// - Strobe latches low and page address bytes.
// - Muxed port drives ones actively.
`timescale 1ns/100ps
module sct_top
  import sct_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Instruction sequencer
  input wire logic instr_valid_i,
  input wire logic [3:0] instr_cycles_i,
  input wire logic instr_xmem_i,
  input wire logic instr_ext_fetch_i,
  input wire logic xmem_we_i,
  input wire logic [23:0] xmem_addr_i,
  input wire logic [7:0] xmem_wdata_i,
  output logic instr_ready_o,
  output logic core_tick_o,
  output logic xmem_done_o,
  output logic [7:0] xmem_rdata_o,
  output logic fetch_refused_o,
  // External memory pins
  input wire logic [7:0] muxed_addr_data_port_i,
  output logic [7:0] muxed_addr_data_port_o,
  output logic muxed_addr_data_port_oe_o,
  output logic [7:0] addr_high_port_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o
);
  typedef struct packed {
    sct_byte_t power_control;
    sct_byte_t timer01_control;
    sct_byte_t timer0_low_count;
    sct_byte_t timer0_high_count;
    sct_byte_t timer2_control;
    sct_byte_t timer2_low_count;
    sct_byte_t timer2_high_count;
    sct_byte_t ext_ram_wait_count;
    sct_byte_t pll_divider_control;
    logic refused;
    logic refused_pulse;
    logic [31:0] dat;
    logic ack;
    logic [7:0] left;
    logic first;
  } sct_st_t;
  sct_st_t s_q, s_d;

  logic tick;
  logic first_half;
  logic x_busy;
  logic x_start;
  logic accept;
  logic wr_en;
  logic rd_en;
  logic [7:0] idx;
  logic [7:0] wbyte;

  // Register index from a byte address
  function automatic logic [7:0] sct_index(input logic [31:0] adr);
    sct_index = adr[9:2];
  endfunction

  // Sixteen-bit count step: returns next low/high pair and overflow
  function automatic logic [16:0] sct_step(input logic [7:0] lo, input logic [7:0] hi);
    sct_step = {1'b0, hi, lo} + 17'h0_0001;
  endfunction

  sct_clkdiv u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .div_i(s_q.pll_divider_control[2:0]),
    .tick_o(tick),
    .first_half_o(first_half)
  );

  sct_xmem u_xmem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .start_i(x_start),
    .we_i(xmem_we_i),
    .addr_i(xmem_addr_i),
    .wdata_i(xmem_wdata_i),
    .wait_i(s_q.ext_ram_wait_count),
    .first_half_i(first_half),
    .busy_o(x_busy),
    .done_o(xmem_done_o),
    .rdata_o(xmem_rdata_o),
    .port0_i(muxed_addr_data_port_i),
    .port0_o(muxed_addr_data_port_o),
    .port0_oe_o(muxed_addr_data_port_oe_o),
    .port2_o(addr_high_port_o),
    .rd_n_o(rd_n_o),
    .wr_n_o(wr_n_o)
  );

  // New instruction only at the last clk_i of a core cycle with none running or the current one in its last cycle.
  // A transfer spans exactly the cycles counted in left, so its last tick may take the next one.
  assign instr_ready_o = tick && (s_q.left <= 8'h01);
  assign accept = instr_ready_o && instr_valid_i;
  // External fetch requests never reach the bus
  assign x_start = accept && instr_xmem_i && !instr_ext_fetch_i;
  assign idx = sct_index(wb_adr_i);
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack && wb_sel_i[0];
  assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !s_q.ack;
  assign wbyte = wb_dat_i[7:0];

  always_comb begin
    logic [16:0] t0;
    logic [16:0] t2;
    t0 = sct_step(s_q.timer0_low_count, s_q.timer0_high_count);
    t2 = sct_step(s_q.timer2_low_count, s_q.timer2_high_count);
    s_d = s_q;
    s_d.refused_pulse = 1'b0;
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;

    // Instruction sequencing in machine cycles
    if (tick) begin
      if (s_q.left > 8'h01) begin
        s_d.left = s_q.left - 8'h01;
        s_d.first = 1'b0;
      end else if (accept) begin
        s_d.first = 1'b1;
        if (instr_ext_fetch_i) begin
          s_d.left = 8'h01;
        end else if (instr_xmem_i) begin
          s_d.left = 8'h02 + s_q.ext_ram_wait_count;
        end else if (instr_cycles_i == 4'h0) begin
          s_d.left = 8'h01;
        end else begin
          s_d.left = {4'h0, instr_cycles_i};
        end
      end else begin
        s_d.left = 8'h00;
        s_d.first = 1'b0;
      end
    end

    // Timers count core cycles, not multi-clock machine cycles
    if (tick && s_q.timer01_control[`SCT_TIMER01_CONTROL_TR0]) begin
      s_d.timer0_low_count = t0[7:0];
      s_d.timer0_high_count = t0[15:8];
    end
    if (tick && s_q.timer2_control[`SCT_TIMER2_CONTROL_TR2]) begin
      s_d.timer2_low_count = t2[7:0];
      s_d.timer2_high_count = t2[15:8];
    end

    // Software writes
    if (wr_en) begin
      case (idx)
        `SCT_IDX_PWR: s_d.power_control = wbyte;
        `SCT_IDX_TIMER01_CONTROL: s_d.timer01_control = wbyte;
        `SCT_IDX_TL0: s_d.timer0_low_count = wbyte;
        `SCT_IDX_TH0: s_d.timer0_high_count = wbyte;
        `SCT_IDX_TIMER2_CONTROL: s_d.timer2_control = wbyte;
        `SCT_IDX_TL2: s_d.timer2_low_count = wbyte;
        `SCT_IDX_TH2: s_d.timer2_high_count = wbyte;
        `SCT_IDX_WAIT: s_d.ext_ram_wait_count = wbyte;
        `SCT_IDX_PLL: s_d.pll_divider_control = wbyte;
        `SCT_IDX_XSTAT: begin
          if (wbyte[`SCT_XSTAT_REFUSED]) begin
            s_d.refused = 1'b0;
          end
        end
        default: s_d.refused = s_d.refused;
      endcase
    end

    // Hardware sets last so they win over a same-cycle clear
    if (tick && s_q.timer01_control[`SCT_TIMER01_CONTROL_TR0] && t0[16]) begin
      s_d.timer01_control[`SCT_TIMER01_CONTROL_TF0] = 1'b1;
    end
    if (tick && s_q.timer2_control[`SCT_TIMER2_CONTROL_TR2] && t2[16]) begin
      s_d.timer2_control[`SCT_TIMER2_CONTROL_TF2] = 1'b1;
    end
    if (accept && instr_ext_fetch_i) begin
      s_d.refused = 1'b1;
      s_d.refused_pulse = 1'b1;
    end

    // Reads; unmapped indices answer zero
    if (rd_en) begin
      case (idx)
        `SCT_IDX_PWR: s_d.dat = {24'h00_0000, s_q.power_control};
        `SCT_IDX_TIMER01_CONTROL: s_d.dat = {24'h00_0000, s_q.timer01_control};
        `SCT_IDX_TL0: s_d.dat = {24'h00_0000, s_q.timer0_low_count};
        `SCT_IDX_TH0: s_d.dat = {24'h00_0000, s_q.timer0_high_count};
        `SCT_IDX_TIMER2_CONTROL: s_d.dat = {24'h00_0000, s_q.timer2_control};
        `SCT_IDX_TL2: s_d.dat = {24'h00_0000, s_q.timer2_low_count};
        `SCT_IDX_TH2: s_d.dat = {24'h00_0000, s_q.timer2_high_count};
        `SCT_IDX_WAIT: s_d.dat = {24'h00_0000, s_q.ext_ram_wait_count};
        `SCT_IDX_PLL: s_d.dat = {24'h00_0000, s_q.pll_divider_control};
        `SCT_IDX_XSTAT: s_d.dat = {30'h0000_0000, s_q.refused, x_busy};
        default: s_d.dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.power_control <= `SCT_RST_PWR;
      s_q.timer01_control <= `SCT_RST_TIMER01_CONTROL;
      s_q.timer0_low_count <= `SCT_RST_CNT;
      s_q.timer0_high_count <= `SCT_RST_CNT;
      s_q.timer2_control <= `SCT_RST_TIMER2_CONTROL;
      s_q.timer2_low_count <= `SCT_RST_CNT;
      s_q.timer2_high_count <= `SCT_RST_CNT;
      s_q.ext_ram_wait_count <= `SCT_RST_WAIT;
      s_q.pll_divider_control <= `SCT_RST_PLL;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;
  assign core_tick_o = tick;
  assign fetch_refused_o = s_q.refused_pulse;
  // High only in the first half of an instruction's first cycle
  assign ale_o = s_q.first && first_half && !s_q.power_control[`SCT_PWR_ALE_OFF];
endmodule

/* tb/sct_properties.sv */
// Port checker for the core bus timing block.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/100ps
module sct_properties (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Core side and pins
  input wire logic instr_ready_o,
  input wire logic core_tick_o,
  input wire logic xmem_done_o,
  input wire logic fetch_refused_o,
  input wire logic muxed_addr_data_port_oe_o,
  input wire logic ale_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  bus_answer_a: assert property (wb_req_s |=> ack_pulse_s)
    else $error("bus request not acked in one cycle");
  ale_half_a: assert property (ale_o |-> !core_tick_o)
    else $error("latch strobe high in second half");
  ale_quiet_a: assert property (!(rd_n_o && wr_n_o) |-> !ale_o)
    else $error("latch strobe high during data strobe");
  strobe_excl_a: assert property (!(!rd_n_o && !wr_n_o))
    else $error("read and write strobes together");
  read_float_a: assert property (!rd_n_o |-> !muxed_addr_data_port_oe_o)
    else $error("port driven during read");
  write_drive_a: assert property (!wr_n_o |-> muxed_addr_data_port_oe_o)
    else $error("port not driven during write");
  fetch_quiet_a: assert property (fetch_refused_o |-> rd_n_o && wr_n_o)
    else $error("bus active on refused fetch");
  ready_tick_a: assert property (instr_ready_o |-> core_tick_o)
    else $error("ready outside core cycle end");
  done_pulse_a: assert property (xmem_done_o |=> !xmem_done_o)
    else $error("done longer than one clock");
endmodule
bind sct_top sct_properties u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .instr_ready_o, .core_tick_o, .xmem_done_o, .fetch_refused_o,
  .muxed_addr_data_port_oe_o, .ale_o, .rd_n_o, .wr_n_o);

/* tb/sct_ram_model.sv */
// External data RAM with its address latch on the muxed port.
// Assumes the bench resolves the port wire and feeds it back here.
`timescale 1ns/100ps
module sct_ram_model (
  // Clock and mode
  input wire logic clk_i,
  input wire logic slow_i,
  // Pins
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] wire_i,
  input wire logic [7:0] page_i,
  output logic [7:0] drive_o
);
  logic [7:0] mem [bit [23:0]];
  logic [7:0] lo_q = 8'h00;
  logic [7:0] pg_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  int age = 0;
  always @(posedge clk_i) begin
    if (ale_i) begin
      lo_q <= wire_i;
      pg_q <= page_i;
    end
    if (!wr_n_i)
      mem[{pg_q, page_i, lo_q}] = wire_i;
    age <= rd_n_i ? 0 : age + 1;
    last_q <= wire_i;
  end
  // Slow mode answers one clock late; undriven port shows inverted data
  always @* begin
    drive_o = ~last_q;
    if (!rd_n_i && age >= slow_i && mem.exists({pg_q, page_i, lo_q}))
      drive_o = mem[{pg_q, page_i, lo_q}];
  end
endmodule

/* tb/single_cycle_core_bus_timing_test.sv */
// Self-checking bench for the core bus timing block.
// Assumes the package, design and RAM model are compiled first.
`timescale 1ns/100ps
`define TB_CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module single_cycle_core_bus_timing_test;
  import sct_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, slow = 0;
  logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o;
  logic [3:0] wb_sel_i = 0, instr_cycles_i = 0;
  logic instr_valid_i = 0, instr_xmem_i = 0, instr_ext_fetch_i = 0, xmem_we_i = 0;
  logic [23:0] xmem_addr_i = 0;
  logic [7:0] xmem_wdata_i = 0, xmem_rdata_o, muxed_addr_data_port_o, addr_high_port_o, ram_drv, q;
  logic wb_ack_o, instr_ready_o, core_tick_o, xmem_done_o, fetch_refused_o;
  logic muxed_addr_data_port_oe_o, ale_o, rd_n_o, wr_n_o;
  wire [7:0] muxed_addr_data_port_i = muxed_addr_data_port_oe_o ? muxed_addr_data_port_o : ram_drv;
  int err_count = 0, tests_run = 0, seed = 24858;
  int clks = 0, ale_n = 0, rd_n = 0, wr_n = 0, ref_n = 0, tcnt = 0, t, p, a0, r0, w0, f0;
  bit t2run = 0;
  logic [7:0] idx_tab [9] = '{8'h87, 8'h88, 8'h8C, 8'hC8, 8'hCC, 8'hCD, 8'h9F, 8'hD7, 8'h90};
  logic [7:0] rst_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  logic [3:0] burst [8] = '{4'h1, 4'h1, 4'h1, 4'h3, 4'h2, 4'h1, 4'h5, 4'h1};
  sct_top u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .instr_valid_i, .instr_cycles_i, .instr_xmem_i, .instr_ext_fetch_i,
    .xmem_we_i, .xmem_addr_i, .xmem_wdata_i, .instr_ready_o, .core_tick_o, .xmem_done_o,
    .xmem_rdata_o, .fetch_refused_o, .muxed_addr_data_port_i, .muxed_addr_data_port_o,
    .muxed_addr_data_port_oe_o, .addr_high_port_o, .ale_o, .rd_n_o, .wr_n_o);
  sct_ram_model u_ram (.clk_i, .slow_i(slow), .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
    .wire_i(muxed_addr_data_port_i), .page_i(addr_high_port_o), .drive_o(ram_drv));
  always #2 clk_i = ~clk_i;
  // Pin activity counts and the timer2 low byte model
  always @(posedge clk_i) begin
    clks <= clks + 1;
    ale_n <= ale_n + (ale_o === 1'b1);
    rd_n <= rd_n + (rd_n_o === 1'b0);
    wr_n <= wr_n + (wr_n_o === 1'b0);
    ref_n <= ref_n + (fetch_refused_o === 1'b1);
    if (t2run && core_tick_o === 1'b1)
      tcnt = tcnt + 1;
    if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i[9:2] == 8'hC8)
      t2run = wb_dat_i[2];
    if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i[9:2] == 8'hCC)
      tcnt = wb_dat_i[7:0];
  end
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'h1;
    wb_adr_i <= {22'h0, idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic issue(input logic [3:0] c, input logic xm, fx, w, input logic [23:0] a, input logic [7:0] d);
    instr_valid_i <= 1'b1;
    instr_cycles_i <= c;
    instr_xmem_i <= xm;
    instr_ext_fetch_i <= fx;
    xmem_we_i <= w;
    xmem_addr_i <= a;
    xmem_wdata_i <= d;
    do @(posedge clk_i); while (instr_ready_o !== 1'b1);
    t = clks;
  endtask
  task automatic end_of_test();
    $display("tests_run %0d err_count %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (idx_tab[i]) begin
      wb(0, idx_tab[i], 8'h00);
      `TB_CHK(q, rst_tab[i])
    end
    wb(1, 8'hD7, 8'h00);
    repeat (20) @(posedge clk_i);
    do @(posedge clk_i); while (core_tick_o !== 1'b1);
    p = clks;
    do @(posedge clk_i); while (core_tick_o !== 1'b1);
    `TB_CHK(clks - p, 2)
    wb(1, 8'hCC, 8'h00);
    wb(1, 8'hC8, 8'h04);
    repeat (10 + ($random(seed) & 63)) @(posedge clk_i);
    wb(1, 8'hC8, 8'h00);
    wb(0, 8'hCC, 8'h00);
    `TB_CHK(q, tcnt[7:0])
    for (int s = 0; s < 2; s++) begin
      wb(1, 8'h87, s ? 8'h10 : 8'h00);
      foreach (burst[i]) begin
        issue(burst[i], 0, 0, 0, 0, 0);
        if (i == 0)
          a0 = ale_n;
        else
          `TB_CHK(t - p, 2 * burst[i - 1])
        p = t;
      end
      instr_valid_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      `TB_CHK(ale_n - a0, s ? 0 : 8)
    end
    wb(1, 8'h87, 8'h00);
    // Reads need a wait of two or more: the port passes four flip-flops before it is sampled
    for (int w = 0; w < 5; w++) begin
      wb(1, 8'h9F, w[7:0]);
      xmem_addr_i <= 24'($random(seed));
      xmem_wdata_i <= 8'($random(seed));
      slow <= (w > 1) ? 1'($random(seed)) : 1'b0;
      @(posedge clk_i);
      r0 = rd_n;
      w0 = wr_n;
      issue(1, 1, 0, 1, xmem_addr_i, xmem_wdata_i);
      p = t;
      if (w > 1)
        issue(1, 1, 0, 0, xmem_addr_i, ~xmem_wdata_i);
      instr_valid_i <= 1'b0;
      if (w > 1)
        `TB_CHK(t - p, 2 * (2 + w))
      repeat (2 * (3 + w)) @(posedge clk_i);
      `TB_CHK(wr_n - w0, 2 * (1 + w))
      if (w > 1) begin
        `TB_CHK(rd_n - r0, 2 * (1 + w))
        `TB_CHK(xmem_rdata_o, ~xmem_wdata_i)
      end
    end
    r0 = rd_n + wr_n;
    f0 = ref_n;
    issue(1, 0, 1, 0, 0, 0);
    issue(1, 0, 0, 0, 0, 0);
    instr_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    `TB_CHK(ref_n - f0, 1)
    `TB_CHK(rd_n + wr_n - r0, 0)
    wb(0, 8'h9E, 8'h00);
    `TB_CHK(q[1], 1'b1)
    end_of_test();
  end
endmodule
